// ---- src/twm_top.sv ----
// Two-wire master controller with Avalon-MM registers
//
// Behaviour
// - Writing the master disable bit freezes any transfer at once.
// - Disabling leaves transfer complete and transmit ready flags as they are.
// - No-ack and complete flags set together; status read clears no-ack.
// - Holding register loads on every byte; a transmit byte overwrites it.
// - Overwrite by a transmit byte raises neither receive ready nor overrun.
// - Software reset mid-frame with clock low blocks all later transfers.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_top
   import twm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic two_wire_clock_pin_i,
   output logic two_wire_clock_pin_o,
   output logic two_wire_clock_pin_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic irq_o
);
   logic wait_q;
   logic [31:0] rdata_q;
   logic [`TWM_ST_W-1:0] status_q;
   logic [`TWM_ST_W-1:0] mask_q;
   logic [`TWM_ST_W-1:0] clr_q;
   logic [`TWM_ST_W-1:0] ev_q;
   logic [`TWM_ST_W-1:0] status_d;
   twm_clk_type clk_q;
   twm_mode_type mode_q;
   logic [7:0] rhr_q;
   logic [7:0] thr_q;
   logic thr_full_q;
   logic en_q;
   logic wedged_q;
   logic stop_req_q;
   logic rd_q;
   logic tx_byte_q;
   logic nack_pend_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   twm_state_type state_q;
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic irq_q;
   logic lo_q;
   logic scl_s;
   logic sda_s;
   logic acc_wr;
   logic acc_rd;
   logic cmd_start;
   logic cmd_stop;
   logic cmd_dis;
   logic cmd_en;
   logic cmd_rst;
   logic ph_active;
   logic ph_hold;
   logic ph_high;
   logic ph_done;
   logic scl_drive;
   logic sda_drive;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction : hit

   assign acc_wr = avs_write && !wait_q;
   assign acc_rd = avs_read && !wait_q;
   assign cmd_start = acc_wr && hit(avs_address, `TWM_OFF_CTRL)
                      && avs_writedata[`TWM_CTRL_START];
   assign cmd_stop = acc_wr && hit(avs_address, `TWM_OFF_CTRL)
                     && avs_writedata[`TWM_CTRL_STOP];
   assign cmd_en = acc_wr && hit(avs_address, `TWM_OFF_CTRL)
                   && avs_writedata[`TWM_CTRL_MSEN];
   assign cmd_dis = acc_wr && hit(avs_address, `TWM_OFF_CTRL)
                    && avs_writedata[`TWM_CTRL_MASTER_DISABLE_BIT];
   assign cmd_rst = acc_wr && hit(avs_address, `TWM_OFF_CTRL)
                    && avs_writedata[`TWM_CTRL_SWRST];
   assign scl_s = scl_sync_q[1];
   assign sda_s = sda_sync_q[1];

   // Line synchronisers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[0], two_wire_clock_pin_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
      end
   end

   // Bus slave: one wait cycle, read data captured as wait drops
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         clr_q <= '0;
      end else begin
         clr_q <= '0;
         if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            if (avs_read) begin
               unique case (avs_address)
                  `TWM_OFF_MODE: rdata_q <= 32'(mode_q);
                  `TWM_OFF_CLK: rdata_q <= 32'(clk_q);
                  `TWM_OFF_STAT: rdata_q <= 32'(status_q);
                  `TWM_OFF_MASK: rdata_q <= 32'(mask_q);
                  `TWM_OFF_RHR: rdata_q <= 32'(rhr_q);
                  default: rdata_q <= 32'h0000_0000;
               endcase
            end
         end else begin
            wait_q <= 1'b1;
         end
         if (acc_rd && hit(avs_address, `TWM_OFF_STAT)) begin
            clr_q <= rdata_q[`TWM_ST_W-1:0];
         end
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_q <= twm_mode_type'(`TWM_MODE_RST);
         clk_q <= twm_clk_type'(`TWM_CLK_RST);
         mask_q <= `TWM_MASK_RST;
      end else if (acc_wr) begin
         if (hit(avs_address, `TWM_OFF_MODE)) begin
            mode_q.addr <= avs_writedata[`TWM_MODE_ADDR_LSB +: 7];
            mode_q.rd <= avs_writedata[`TWM_MODE_RD];
         end
         if (hit(avs_address, `TWM_OFF_CLK)) begin
            clk_q.clock_low_divider <= avs_writedata[`TWM_CLK_LDIV_LSB +: 8];
            clk_q.clock_high_divider <= avs_writedata[`TWM_CLK_HDIV_LSB +: 8];
            clk_q.clock_divider_exponent <= avs_writedata[`TWM_CLK_EXP_LSB +: 3];
         end
         if (hit(avs_address, `TWM_OFF_MASK)) begin
            mask_q <= avs_writedata[`TWM_ST_W-1:0];
         end
      end
   end

   // Enable and the stuck state left by an ill-timed software reset
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         wedged_q <= 1'b0;
      end else begin
         if (cmd_dis) begin
            en_q <= 1'b0;
         end else if (cmd_en) begin
            en_q <= 1'b1;
         end
         if (cmd_rst && state_q != TWM_IDLE && !scl_s) begin
            wedged_q <= 1'b1;
         end
      end
   end

   // Sticky status; a set in the clearing cycle wins
   always_comb begin
      status_d = (status_q & ~clr_q) | ev_q;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || cmd_rst) begin
         status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q <= |(status_d & mask_q);
      end
   end

   // Transmit holding register
   always_ff @(posedge core_clk_i) begin
      if (rst_i || cmd_rst) begin
         thr_q <= 8'h00;
      end else if (acc_wr && hit(avs_address, `TWM_OFF_THR)) begin
         thr_q <= avs_writedata[7:0];
      end
   end

   assign ph_active = (state_q != TWM_IDLE) && (state_q != TWM_HOLD);
   assign ph_high = (state_q == TWM_START) || (state_q == TWM_HIGH)
                    || (state_q == TWM_STOP_HIGH) || (state_q == TWM_STOP_END);
   assign ph_hold = !en_q || (ph_high && !scl_s);

   twm_phase u_phase (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i || cmd_rst),
      .active_i(ph_active),
      .hold_i(ph_hold),
      .high_i(ph_high),
      .clk_cfg_i(clk_q),
      .done_o(ph_done)
   );

   // Frame sequencer; it stands still while the master is disabled
   always_ff @(posedge core_clk_i) begin
      if (rst_i || cmd_rst) begin
         state_q <= TWM_IDLE;
         ev_q <= '0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         rhr_q <= 8'h00;
         thr_full_q <= 1'b0;
         stop_req_q <= 1'b0;
         rd_q <= 1'b0;
         tx_byte_q <= 1'b0;
         nack_pend_q <= 1'b0;
      end else begin
         ev_q <= '0;
         if (acc_wr && hit(avs_address, `TWM_OFF_THR)) begin
            thr_full_q <= 1'b1;
         end
         if (cmd_stop) begin
            stop_req_q <= 1'b1;
         end
         if (en_q) begin
            unique case (state_q)
               TWM_IDLE: begin
                  if (cmd_start && !wedged_q) begin
                     state_q <= TWM_START;
                     rd_q <= mode_q.rd;
                     shift_q <= {mode_q.addr, mode_q.rd};
                     tx_byte_q <= 1'b1;
                     bit_q <= 4'h0;
                     nack_pend_q <= 1'b0;
                  end
               end
               TWM_START: begin
                  if (ph_done) begin
                     state_q <= TWM_LOW;
                  end
               end
               TWM_LOW: begin
                  if (ph_done) begin
                     state_q <= TWM_HIGH;
                  end
               end
               TWM_HIGH: begin
                  if (ph_done && bit_q != 4'h8) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bit_q <= bit_q + 4'h1;
                     state_q <= TWM_LOW;
                  end else if (ph_done) begin
                     rhr_q <= shift_q;
                     bit_q <= 4'h0;
                     if (!tx_byte_q) begin
                        ev_q[`TWM_ST_RECEIVE_READY_FLAG] <= 1'b1;
                        ev_q[`TWM_ST_OVR] <= status_q[`TWM_ST_RECEIVE_READY_FLAG];
                     end
                     if (tx_byte_q && sda_s) begin
                        nack_pend_q <= 1'b1;
                        state_q <= TWM_STOP_LOW;
                     end else if (rd_q) begin
                        tx_byte_q <= 1'b0;
                        state_q <= (stop_req_q && !tx_byte_q) ? TWM_STOP_LOW
                                                              : TWM_LOW;
                     end else begin
                        state_q <= TWM_HOLD;
                     end
                  end
               end
               TWM_HOLD: begin
                  if (thr_full_q) begin
                     shift_q <= thr_q;
                     thr_full_q <= 1'b0;
                     tx_byte_q <= 1'b1;
                     ev_q[`TWM_ST_TRANSMIT_READY_FLAG] <= 1'b1;
                     state_q <= TWM_LOW;
                  end else if (stop_req_q) begin
                     state_q <= TWM_STOP_LOW;
                  end
               end
               TWM_STOP_LOW: begin
                  if (ph_done) begin
                     state_q <= TWM_STOP_HIGH;
                  end
               end
               TWM_STOP_HIGH: begin
                  if (ph_done) begin
                     state_q <= TWM_STOP_END;
                  end
               end
               TWM_STOP_END: begin
                  if (ph_done) begin
                     state_q <= TWM_IDLE;
                     stop_req_q <= 1'b0;
                     ev_q[`TWM_ST_TRANSFER_COMPLETE_FLAG] <= 1'b1;
                     ev_q[`TWM_ST_NACK] <= nack_pend_q;
                  end
               end
               default: begin
                  state_q <= TWM_IDLE;
               end
            endcase
         end
      end
   end

   // Open-drain drive: enable high pulls the line low
   always_comb begin
      scl_drive = (state_q == TWM_LOW) || (state_q == TWM_HOLD)
                  || (state_q == TWM_STOP_LOW);
      sda_drive = 1'b0;
      unique case (state_q)
         TWM_START, TWM_STOP_LOW, TWM_STOP_HIGH: sda_drive = 1'b1;
         TWM_LOW, TWM_HIGH: begin
            if (bit_q != 4'h8) begin
               sda_drive = tx_byte_q && !shift_q[7];
            end else begin
               sda_drive = !tx_byte_q && !stop_req_q;
            end
         end
         default: sda_drive = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         lo_q <= 1'b0;
      end else begin
         scl_oe_q <= scl_drive;
         sda_oe_q <= sda_drive;
         lo_q <= 1'b0;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign two_wire_clock_pin_o = lo_q;
   assign two_wire_clock_pin_oe_o = scl_oe_q;
   assign sda_o = lo_q;
   assign sda_oe_o = sda_oe_q;
   assign irq_o = irq_q;
endmodule : twm_top

// ---- src/twm_params.svh ----
// Register offsets, field positions and reset values of the two-wire master
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH
`define TWM_OFF_CTRL 5'h00
`define TWM_OFF_MODE 5'h04
`define TWM_OFF_CLK 5'h08
`define TWM_OFF_STAT 5'h0c
`define TWM_OFF_MASK 5'h10
`define TWM_OFF_RHR 5'h14
`define TWM_OFF_THR 5'h18
`define TWM_CTRL_START 0
`define TWM_CTRL_STOP 1
`define TWM_CTRL_MSEN 2
`define TWM_CTRL_MASTER_DISABLE_BIT 3
`define TWM_CTRL_SWRST 7
`define TWM_MODE_ADDR_LSB 0
`define TWM_MODE_RD 8
`define TWM_CLK_LDIV_LSB 0
`define TWM_CLK_HDIV_LSB 8
`define TWM_CLK_EXP_LSB 16
`define TWM_ST_TRANSFER_COMPLETE_FLAG 0
`define TWM_ST_RECEIVE_READY_FLAG 1
`define TWM_ST_TRANSMIT_READY_FLAG 2
`define TWM_ST_OVR 6
`define TWM_ST_NACK 8
`define TWM_ST_W 9
`define TWM_MODE_RST 32'h0000_0000
`define TWM_CLK_RST 32'h0000_3232
`define TWM_MASK_RST 9'h000
`endif

// ---- src/twm_pkg.sv ----
// Types shared by the two-wire master files
package twm_pkg;
   typedef enum logic [3:0] {
      TWM_IDLE = 4'b0000,
      TWM_START = 4'b0001,
      TWM_LOW = 4'b0010,
      TWM_HIGH = 4'b0011,
      TWM_HOLD = 4'b0100,
      TWM_STOP_LOW = 4'b0101,
      TWM_STOP_HIGH = 4'b0110,
      TWM_STOP_END = 4'b0111
   } twm_state_type;

   typedef struct packed {
      logic [2:0] clock_divider_exponent;
      logic [7:0] clock_high_divider;
      logic [7:0] clock_low_divider;
   } twm_clk_type;

   typedef struct packed {
      logic rd;
      logic [6:0] addr;
   } twm_mode_type;
endpackage : twm_pkg

// ---- src/twm_phase.sv ----
// Serial clock phase timer: low or high phase length from the dividers
`timescale 1ns/10ps
module twm_phase
   import twm_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic active_i,
   input wire logic hold_i,
   input wire logic high_i,
   input wire twm_clk_type clk_cfg_i,
   output logic done_o
);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] len;

   function automatic logic [CW-1:0] phase_len(input logic [7:0] div,
                                                input logic [2:0] expo);
      logic [CW-1:0] l;
      l = CW'(div) << expo;
      phase_len = (l == '0) ? CW'(1) : l;
   endfunction : phase_len

   always_comb begin
      len = high_i ? phase_len(clk_cfg_i.clock_high_divider,
                               clk_cfg_i.clock_divider_exponent)
                   : phase_len(clk_cfg_i.clock_low_divider,
                               clk_cfg_i.clock_divider_exponent);
   end

   assign done_o = active_i && !hold_i && (cnt_q == len - CW'(1));

   always_ff @(posedge core_clk_i) begin
      if (rst_i || !active_i) begin
         cnt_q <= '0;
      end else if (!hold_i) begin
         cnt_q <= done_o ? '0 : cnt_q + CW'(1);
      end
   end
endmodule : twm_phase

// ---- verification/twm_top_props.sv ----
// Port-level checks of the two-wire master
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_top_props
   import twm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic two_wire_clock_pin_i,
   input wire logic two_wire_clock_pin_o,
   input wire logic two_wire_clock_pin_oe_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic irq_o
);
   logic acc, cw, sr, soe, mrd_q, rxf_q, wdg_q;
   logic [18:0] clk_q;
   logic [15:0] cnt_q, lo_min, hi_min;
   assign soe = two_wire_clock_pin_oe_o;
   assign acc = (avs_read || avs_write) && !avs_waitrequest;
   assign cw = acc && avs_write && avs_address == `TWM_OFF_CTRL;
   assign sr = acc && avs_read && avs_address == `TWM_OFF_STAT;
   assign lo_min = {8'h00, clk_q[7:0]} << clk_q[18:16];
   assign hi_min = {8'h00, clk_q[15:8]} << clk_q[18:16];
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         clk_q <= 19'h03232;
         mrd_q <= 1'b0;
      end else if (acc && avs_write) begin
         if (avs_address == `TWM_OFF_CLK) clk_q <= avs_writedata[18:0];
         if (avs_address == `TWM_OFF_MODE) mrd_q <= avs_writedata[8];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i || sr) rxf_q <= 1'b0;
      else if (cw && avs_writedata[0] && mrd_q) rxf_q <= 1'b1;
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) wdg_q <= 1'b0;
      else if (cw && avs_writedata[7] && soe) wdg_q <= 1'b1;
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) cnt_q <= 16'h0000;
      else if ($changed(soe)) cnt_q <= 16'h0001;
      else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_frozen;
      ($stable(soe) && $stable(sda_oe_o)) [*4];
   endsequence
   AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> s_answer) else $error("one wait cycle broken");
   AST_UNMAPPED: assert property (acc && avs_read && avs_address > 5'h18
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   AST_FREEZE: assert property (cw && avs_writedata[3] |-> ##3 s_frozen)
      else $error("pins moved while disabled");
   AST_KEEP_FLAGS: assert property (cw && avs_writedata[3]
      |-> ##2 $stable(irq_o) [*3]) else $error("disable changed flags");
   AST_NACK_COMP: assert property (sr && avs_readdata[8]
      |-> avs_readdata[0]) else $error("no-ack without complete");
   AST_RX_READ: assert property (sr && (avs_readdata[1] || avs_readdata[6])
      |-> rxf_q) else $error("receive flag without read frame");
   AST_WEDGE: assert property (wdg_q && $past(wdg_q, 3)
      |-> !soe && !sda_oe_o) else $error("frame after wedge");
   AST_LOW_PHASE: assert property ($fell(soe) && !wdg_q
      |-> cnt_q >= lo_min) else $error("low phase short");
   AST_HIGH_PHASE: assert property ($rose(soe) && !wdg_q
      |-> cnt_q >= hi_min) else $error("high phase short");
endmodule : twm_top_props
bind twm_top twm_top_props u_twm_top_props (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .two_wire_clock_pin_i(two_wire_clock_pin_i),
   .two_wire_clock_pin_o(two_wire_clock_pin_o),
   .two_wire_clock_pin_oe_o(two_wire_clock_pin_oe_o), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// ---- verification/twm_slave_model.sv ----
// Behavioural two-wire slave answering the master under test
`timescale 1ns/10ps
module twm_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a,
   parameter logic [7:0] RD_DATA = 8'h5a
) (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_pull_o
);
   logic sc_q = 1'b1;
   logic sd_q = 1'b1;
   logic sel = 1'b0;
   logic adr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [7:0] txb = RD_DATA;
   int bitn = 9;
   initial sda_pull_o = 1'b0;
   always @(scl_i or sda_i) begin
      if (scl_i && sc_q && sd_q && !sda_i) begin
         bitn = 0;
         adr = 1'b1;
         sel = 1'b0;
      end else if (scl_i && !sc_q) begin
         if (bitn < 8) sh = {sh[6:0], sda_i};
         if (bitn == 7 && adr) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
         end
         if (bitn == 8) begin
            if (rd && !adr && sda_i) sel = 1'b0;
            if (rd && !adr) txb = txb + 8'h01;
            adr = 1'b0;
            bitn = 0;
         end else if (bitn < 8) bitn = bitn + 1;
      end else if (!scl_i && sc_q) begin
         sda_pull_o = sel && ((bitn == 8 && (adr || !rd)) ||
                      (bitn < 8 && rd && !adr && !txb[7 - bitn]));
      end
      sc_q = scl_i;
      sd_q = sda_i;
   end
endmodule : twm_slave_model

// ---- verification/twm_top_bench.sv ----
// Register-level bench of the two-wire master with a slave model
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_top_bench;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, scl_o, scl_oe, sda_o, sda_oe, irq_o, pull;
   logic [1:0] pins;
   int miscompares = 0;
   int tests_run = 0;
   int n;
   wire scl = (scl_oe !== 1'b1);
   wire sda = !(sda_oe === 1'b1 || pull === 1'b1);
   always #5 core_clk_i = ~core_clk_i;
   twm_top u_twm_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .two_wire_clock_pin_i(scl),
      .two_wire_clock_pin_o(scl_o), .two_wire_clock_pin_oe_o(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq_o));
   twm_slave_model u_twm_slave_model (.scl_i(scl), .sda_i(sda),
      .sda_pull_o(pull));
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic tmo;
      miscompares++;
      $display("unexpected wait expected end seen timeout");
      report_and_stop();
   endtask : tmo
   task automatic chk(input string nm, input logic [31:0] e, s);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge core_clk_i);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      k = 0;
      do begin
         @(posedge core_clk_i);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k >= 40) tmo();
   endtask : bus
   task automatic rdchk(input logic [4:0] a, input logic [31:0] m, e,
                        input string nm);
      bus(a, 1'b0, 32'h0);
      chk(nm, e, q & m);
   endtask : rdchk
   task automatic chkirq(input logic e, input string nm);
      repeat (2) @(negedge core_clk_i);
      chk(nm, {31'h0, e}, {31'h0, irq_o});
   endtask : chkirq
   task automatic wait_irq;
      int k;
      k = 0;
      while (irq_o !== 1'b1 && k < 20000) begin
         @(negedge core_clk_i);
         k++;
      end
      if (k >= 20000) tmo();
   endtask : wait_irq
   task automatic rises(input int lim, input int want);
      logic p;
      int k;
      p = scl_oe;
      n = 0;
      for (k = 0; k < lim && n < want; k++) begin
         @(negedge core_clk_i);
         if (scl_oe === 1'b1 && p !== 1'b1) n++;
         p = scl_oe;
      end
   endtask : rises
   initial begin
      repeat (12) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rdchk(`TWM_OFF_CLK, 32'hffffffff, 32'h3232, "clk reset");
      rdchk(`TWM_OFF_MASK, 32'h1ff, 32'h0, "mask reset");
      rdchk(5'h1c, 32'hffffffff, 32'h0, "unmapped read");
      bus(`TWM_OFF_CLK, 1'b1, 32'h0808);
      rdchk(`TWM_OFF_CLK, 32'h7ffff, 32'h0808, "clk written");
      bus(`TWM_OFF_MASK, 1'b1, 32'h1);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h4);
      $display("test registers done");
      bus(`TWM_OFF_MODE, 1'b1, 32'h12a);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h1);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h2);
      wait_irq();
      rdchk(`TWM_OFF_STAT, 32'h143, 32'h003, "read frame status");
      rdchk(`TWM_OFF_RHR, 32'hff, 32'h5a, "received byte");
      $display("test read frame done");
      bus(`TWM_OFF_MODE, 1'b1, 32'h02a);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h1);
      bus(`TWM_OFF_THR, 1'b1, 32'h96);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h2);
      wait_irq();
      bus(`TWM_OFF_MASK, 1'b1, 32'h0);
      chkirq(1'b0, "irq masked");
      bus(`TWM_OFF_MASK, 1'b1, 32'h1);
      chkirq(1'b1, "irq unmasked");
      rdchk(`TWM_OFF_STAT, 32'h143, 32'h001, "write frame status");
      chkirq(1'b0, "irq cleared");
      rdchk(`TWM_OFF_RHR, 32'hff, 32'h96, "overwritten byte");
      $display("test write frame done");
      bus(`TWM_OFF_MODE, 1'b1, 32'h011);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h1);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h2);
      wait_irq();
      rdchk(`TWM_OFF_STAT, 32'h143, 32'h101, "nack status");
      rdchk(`TWM_OFF_STAT, 32'h143, 32'h000, "nack cleared");
      $display("test no-ack done");
      bus(`TWM_OFF_MODE, 1'b1, 32'h02a);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h1);
      bus(`TWM_OFF_THR, 1'b1, 32'h55);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h2);
      rises(5000, 12);
      if (n != 12) tmo();
      bus(`TWM_OFF_MASK, 1'b1, 32'h0);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h8);
      repeat (3) @(negedge core_clk_i);
      pins = {scl_oe, sda_oe};
      repeat (30) @(negedge core_clk_i);
      chk("frozen pins", {30'h0, pins}, {30'h0, scl_oe, sda_oe});
      rdchk(`TWM_OFF_STAT, 32'h4, 32'h4, "ready kept");
      bus(`TWM_OFF_CTRL, 1'b1, 32'h4);
      bus(`TWM_OFF_MASK, 1'b1, 32'h1);
      wait_irq();
      rdchk(`TWM_OFF_STAT, 32'h1, 32'h1, "resumed frame done");
      $display("test disable done");
      bus(`TWM_OFF_CTRL, 1'b1, 32'h1);
      rises(5000, 3);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h80);
      bus(`TWM_OFF_CTRL, 1'b1, 32'h1);
      rises(600, 1);
      chk("start after wedge", 32'h0, n);
      $display("test soft reset done");
      report_and_stop();
   end
endmodule : twm_top_bench
